// ### src/serializer_addr_power_reset_regs_params.svh
/*
  Offsets, field positions, reset values and timing counts of the bus address
  and power/reset control registers.
  Assumes inclusion by bare name from the register module.
*/
`ifndef SERIALIZER_ADDR_POWER_RESET_REGS_PARAMS_SVH
`define SERIALIZER_ADDR_POWER_RESET_REGS_PARAMS_SVH

// ==========================================================================
// Register offsets
`define BUS_ADDRESS_CONFIG_OFFSET      8'h00
`define POWER_AND_RESET_CONTROL_OFFSET 8'h01

// ==========================================================================
// Reset values
`define BUS_ADDRESS_CONFIG_RESET       8'hb0
`define POWER_AND_RESET_CONTROL_RESET  8'h30

// ==========================================================================
// Field positions
`define ADDR_SOURCE_SELECT_BIT         0
`define OWN_ADDR_MSB                   7
`define OWN_ADDR_LSB                   1
`define RESERVED_HIGH_BIT              7
`define DRIVE_STRENGTH_BIT             6
`define SUPPLY_AUTODETECT_BIT          5
`define SUPPLY_LEVEL_BIT               4
`define ANALOG_POWER_DOWN_BIT          3
`define RESERVED_LOW_BIT               2
`define LOGIC_RESET_BIT                1
`define FULL_RESET_BIT                 0

// ==========================================================================
// Writable mask of the power and reset register
`define POWER_RESET_WRITE_MASK         8'h7b

// ==========================================================================
// Timing counts
`define SOFT_RESET_PULSE_NS            10
`define CLK_PERIOD_NS                  10
`define SOFT_RESET_PULSE_CYCLES        ((`SOFT_RESET_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### src/serializer_regs_pkg.sv
/*
  Types for the serializer control register bank.
  Assumes nothing of its surroundings.
*/
package serializer_regs_pkg;

  // ========================================================================
  // Access source
  typedef enum logic [0:0] {
    SRC_LOCAL  = 1'b0,
    SRC_REMOTE = 1'b1
  } access_source_t;

  typedef logic [7:0] reg_byte_t;

endpackage

// ### src/serializer_addr_power_reset_regs.sv
/*
  Bus address and power/reset control registers of the serializer, with a
  local bus port and a remote control channel port.
  Assumes the local bus decoder and the channel logic run on i_core_clk and
  offer at most one access per port per cycle; local wins a same-cycle clash.
*/
//
// Behaviour
// - Registers readable and writable from local bus and remote channel ports.
// - Unlisted offsets are reserved: writes ignored, reads return zero.
// - Address register bits 7:1 hold own address, default 0x58.
// - Address bit 0 chooses strap pins (0) or register address (1).
// - Power bit 6 sets output drive strength, 1 is high.
// - Power bit 5 enables I/O supply auto-detect.
// - Power bit 4 selects 3.3V (1) or 1.8V (0) I/O supply.
// - Analog power-down bit accepts local writes only.
// - Analog power-down bit 1 powers the analog block down.
// - Power bit 1 pulses a logic reset keeping registers, self-clears.
// - Power bit 0 resets logic and all registers, self-clears.
`timescale 1ns/10ps
`include "serializer_addr_power_reset_regs_params.svh"

module serializer_addr_power_reset_regs #(
  parameter int ADDR_W = 8
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_reset_n,
  input  wire logic              i_local_wr,
  input  wire logic              i_local_rd,
  input  wire logic [ADDR_W-1:0] i_local_addr,
  input  wire logic [7:0]        i_local_wdata,
  output logic      [7:0]        o_local_rdata,
  output logic                   o_local_rvalid,
  input  wire logic              i_remote_wr,
  input  wire logic              i_remote_rd,
  input  wire logic [ADDR_W-1:0] i_remote_addr,
  input  wire logic [7:0]        i_remote_wdata,
  output logic      [7:0]        o_remote_rdata,
  output logic                   o_remote_rvalid,
  input  wire logic [6:0]        i_address_strap_pins,
  output logic      [6:0]        o_own_bus_address,
  output logic                   o_output_drive_strength,
  output logic                   o_io_supply_autodetect,
  output logic                   o_io_supply_level_select,
  output logic                   o_analog_power_down,
  output logic                   o_logic_reset,
  output logic                   o_full_reset
);

  // ========================================================================
  // Strap synchroniser
  logic [6:0] strap_meta_q;
  logic [6:0] strap_sync_q;

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      strap_meta_q <= 7'h00;
      strap_sync_q <= 7'h00;
    end else begin
      strap_meta_q <= i_address_strap_pins;
      strap_sync_q <= strap_meta_q;
    end
  end

  // ========================================================================
  // Register state
  logic [7:0] addr_cfg_q;
  logic [7:0] addr_cfg_d;
  logic [7:0] pwr_q;
  logic [7:0] pwr_d;
  logic       logic_rst_q;
  logic       logic_rst_d;
  logic       full_rst_q;
  logic       full_rst_d;
  logic [7:0] local_rdata_q;
  logic [7:0] local_rdata_d;
  logic       local_rvalid_q;
  logic       local_rvalid_d;
  logic [7:0] remote_rdata_q;
  logic [7:0] remote_rdata_d;
  logic       remote_rvalid_q;
  logic       remote_rvalid_d;
  logic [6:0] own_addr_q;
  logic [6:0] own_addr_d;

  function automatic logic [7:0] read_reg(input logic [ADDR_W-1:0] a,
                                          input logic [7:0] ac,
                                          input logic [7:0] pw);
    logic [7:0] r;
    r = 8'h00;
    if (a == ADDR_W'(`BUS_ADDRESS_CONFIG_OFFSET)) begin
      r = ac;
    end else if (a == ADDR_W'(`POWER_AND_RESET_CONTROL_OFFSET)) begin
      r = pw;
    end
    return r;
  endfunction

  // ========================================================================
  // Write port selection
  serializer_regs_pkg::access_source_t wr_src;
  logic                                wr_en;
  logic [ADDR_W-1:0]                   wr_addr;
  serializer_regs_pkg::reg_byte_t      wr_data;
  serializer_regs_pkg::reg_byte_t      wmask;
  logic                                wr_cfg_hit;
  logic                                wr_pwr_hit;

  always_comb begin
    wr_en  = i_local_wr | i_remote_wr;
    wr_src = serializer_regs_pkg::SRC_REMOTE;
    if (i_local_wr) begin
      wr_src = serializer_regs_pkg::SRC_LOCAL;
    end
    wr_addr = i_local_wr ? i_local_addr : i_remote_addr;
    wr_data = i_local_wr ? i_local_wdata : i_remote_wdata;
    wmask   = `POWER_RESET_WRITE_MASK;
    if (wr_src == serializer_regs_pkg::SRC_REMOTE) begin
      wmask[`ANALOG_POWER_DOWN_BIT] = 1'b0;
    end
    wr_cfg_hit = wr_en && !full_rst_q && (wr_addr == ADDR_W'(`BUS_ADDRESS_CONFIG_OFFSET));
    wr_pwr_hit = wr_en && !full_rst_q && (wr_addr == ADDR_W'(`POWER_AND_RESET_CONTROL_OFFSET));
  end

  // ========================================================================
  // Register contents
  always_comb begin
    addr_cfg_d = addr_cfg_q;
    pwr_d      = pwr_q;
    if (wr_cfg_hit) begin
      addr_cfg_d = wr_data;
    end
    if (wr_pwr_hit) begin
      pwr_d = (pwr_q & ~wmask) | (wr_data & wmask);
    end
    pwr_d[`LOGIC_RESET_BIT] = 1'b0;
    pwr_d[`FULL_RESET_BIT]  = 1'b0;
    if (full_rst_q) begin
      addr_cfg_d = `BUS_ADDRESS_CONFIG_RESET;
      pwr_d      = `POWER_AND_RESET_CONTROL_RESET;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      addr_cfg_q <= `BUS_ADDRESS_CONFIG_RESET;
      pwr_q      <= `POWER_AND_RESET_CONTROL_RESET;
    end else begin
      addr_cfg_q <= addr_cfg_d;
      pwr_q      <= pwr_d;
    end
  end

  // ========================================================================
  // Soft reset pulses
  always_comb begin
    logic_rst_d = 1'b0;
    full_rst_d  = 1'b0;
    if (wr_pwr_hit) begin
      logic_rst_d = wr_data[`LOGIC_RESET_BIT] | wr_data[`FULL_RESET_BIT];
      full_rst_d  = wr_data[`FULL_RESET_BIT];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      logic_rst_q <= 1'b0;
      full_rst_q  <= 1'b0;
    end else begin
      logic_rst_q <= logic_rst_d;
      full_rst_q  <= full_rst_d;
    end
  end

  // ========================================================================
  // Own bus address
  always_comb begin
    own_addr_d = strap_sync_q;
    if (addr_cfg_q[`ADDR_SOURCE_SELECT_BIT]) begin
      own_addr_d = addr_cfg_q[`OWN_ADDR_MSB:`OWN_ADDR_LSB];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      own_addr_q <= 7'h00;
    end else begin
      own_addr_q <= own_addr_d;
    end
  end

  // ========================================================================
  // Read paths
  always_comb begin
    local_rvalid_d  = i_local_rd && !full_rst_q;
    remote_rvalid_d = i_remote_rd && !full_rst_q;
    local_rdata_d   = 8'h00;
    remote_rdata_d  = 8'h00;
    if (local_rvalid_d) begin
      local_rdata_d = read_reg(i_local_addr, addr_cfg_q, pwr_q);
    end
    if (remote_rvalid_d) begin
      remote_rdata_d = read_reg(i_remote_addr, addr_cfg_q, pwr_q);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      local_rdata_q   <= 8'h00;
      local_rvalid_q  <= 1'b0;
      remote_rdata_q  <= 8'h00;
      remote_rvalid_q <= 1'b0;
    end else begin
      local_rdata_q   <= local_rdata_d;
      local_rvalid_q  <= local_rvalid_d;
      remote_rdata_q  <= remote_rdata_d;
      remote_rvalid_q <= remote_rvalid_d;
    end
  end

  // ========================================================================
  // Outputs
  assign o_local_rdata            = local_rdata_q;
  assign o_local_rvalid           = local_rvalid_q;
  assign o_remote_rdata           = remote_rdata_q;
  assign o_remote_rvalid          = remote_rvalid_q;
  assign o_own_bus_address        = own_addr_q;
  assign o_output_drive_strength  = pwr_q[`DRIVE_STRENGTH_BIT];
  assign o_io_supply_autodetect   = pwr_q[`SUPPLY_AUTODETECT_BIT];
  assign o_io_supply_level_select = pwr_q[`SUPPLY_LEVEL_BIT];
  assign o_analog_power_down      = pwr_q[`ANALOG_POWER_DOWN_BIT];
  assign o_logic_reset            = logic_rst_q;
  assign o_full_reset             = full_rst_q;

endmodule

// ### tb/regs_chk_sva.sv
/* Port checker of the register bank.
   Assumes a bind onto the register module. */
`timescale 1ns/10ps
module regs_chk (
  input logic       i_core_clk,
  input logic       i_reset_n,
  input logic       i_local_wr,
  input logic       i_local_rd,
  input logic [7:0] i_local_addr,
  input logic [7:0] i_local_wdata,
  input logic [7:0] o_local_rdata,
  input logic       o_local_rvalid,
  input logic       i_remote_wr,
  input logic [7:0] i_remote_addr,
  input logic [7:0] i_remote_wdata,
  input logic       o_output_drive_strength,
  input logic       o_analog_power_down,
  input logic       o_logic_reset,
  input logic       o_full_reset
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  logic w1, wv, wf, rv;
  assign w1 = i_local_wr && i_local_addr == 8'h01 && !o_full_reset;
  assign wv = w1 && !i_local_wdata[0];
  assign wf = w1 && i_local_wdata[0];
  assign rv = i_remote_wr && i_remote_addr == 8'h01 && !i_remote_wdata[0] && !i_local_wr
              && !o_full_reset;
  // ==========
  // Assertions
  AST_DRV: assert property (wv |=> o_output_drive_strength == $past(i_local_wdata[6]))
    else $error("bad drive");
  AST_APD: assert property (wv |=> o_analog_power_down == $past(i_local_wdata[3]))
    else $error("bad power-down");
  AST_RAPD: assert property (rv |=> $stable(o_analog_power_down))
    else $error("remote power-down");
  AST_FULL:
    assert property (wf |=> o_full_reset && o_logic_reset ##1 !o_full_reset && !o_analog_power_down)
    else $error("bad full reset");
  AST_LRST: assert property (wv && i_local_wdata[1] |=> o_logic_reset && !o_full_reset)
    else $error("bad logic reset");
  AST_RV: assert property (i_local_rd && !o_full_reset |=> o_local_rvalid)
    else $error("no read valid");
  AST_UNMAP: assert property (i_local_rd && i_local_addr > 8'h01 |=> o_local_rdata == 8'h00)
    else $error("unmapped data");
  AST_RSV:
    assert property (i_local_rd && i_local_addr == 8'h01 |=> (o_local_rdata & 8'h87) == 8'h00)
    else $error("reserved bits");
  cover property (wf);
  cover property (rv);
  cover property (i_local_rd && i_local_addr > 8'h01);
endmodule
bind serializer_addr_power_reset_regs regs_chk u_chk (
  .i_core_clk, .i_reset_n, .i_local_wr, .i_local_rd, .i_local_addr, .i_local_wdata,
  .o_local_rdata, .o_local_rvalid, .i_remote_wr, .i_remote_addr, .i_remote_wdata,
  .o_output_drive_strength, .o_analog_power_down, .o_logic_reset, .o_full_reset);

// ### tb/host_model.sv
/* Host model making local (0) and remote (1) register accesses.
   Assumes one access at a time on i_core_clk. */
`timescale 1ns/10ps
module host_model (
  input  logic            i_core_clk,
  output logic [1:0]      o_wr,
  output logic [1:0]      o_rd,
  output logic [1:0][7:0] o_addr,
  output logic [1:0][7:0] o_wdata,
  input  logic [1:0]      i_rvalid,
  input  logic [1:0][7:0] i_rdata,
  output logic            o_timeout
);
  initial {o_wr, o_rd, o_addr, o_wdata, o_timeout} = '0;
  always @(posedge i_core_clk) begin
    if (!(|{o_wr, o_rd})) begin
      o_addr <= ~o_addr;
      o_wdata <= ~o_wdata;
    end
  end
  task automatic acc(input bit p, w, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge i_core_clk);
    #1;
    o_wr[p] = w;
    o_rd[p] = !w;
    o_addr[p] = a;
    o_wdata[p] = (p && a == 8'h01) ? d & 8'h7b : d;
    @(posedge i_core_clk);
    #1;
    {o_wr, o_rd} = '0;
    q = i_rdata[p];
    if (!w && i_rvalid[p] !== 1'b1) o_timeout = 1'b1;
  endtask
endmodule

// ### tb/tb_top.sv
/* Self-checking bench of the register bank.
   Assumes the host model drives both request ports. */
`timescale 1ns/10ps
module tb_top;
  logic            clk = 1'b0;
  logic            rst_n = 1'b0;
  logic [6:0]      strap = 7'h00;
  logic [6:0]      own;
  logic [1:0]      wr, rd, rvalid;
  logic [1:0][7:0] addr, wdata, rdata;
  logic            drv, aut, lvl, apd, tmo, lrst, frst;
  logic [7:0]      q, w, e1;
  int              num_errors = 0;
  int              n_checks = 0;
  always #5 clk = ~clk;
  serializer_addr_power_reset_regs u_dut (.i_core_clk(clk), .i_reset_n(rst_n),
    .i_local_wr(wr[0]), .i_local_rd(rd[0]), .i_local_addr(addr[0]), .i_local_wdata(wdata[0]),
    .o_local_rdata(rdata[0]), .o_local_rvalid(rvalid[0]), .i_remote_wr(wr[1]),
    .i_remote_rd(rd[1]), .i_remote_addr(addr[1]), .i_remote_wdata(wdata[1]),
    .o_remote_rdata(rdata[1]), .o_remote_rvalid(rvalid[1]), .i_address_strap_pins(strap),
    .o_own_bus_address(own), .o_output_drive_strength(drv), .o_io_supply_autodetect(aut),
    .o_io_supply_level_select(lvl), .o_analog_power_down(apd), .o_logic_reset(lrst),
    .o_full_reset(frst));
  host_model u_host (.i_core_clk(clk), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata),
    .i_rvalid(rvalid), .i_rdata(rdata), .o_timeout(tmo));
  function automatic logic [7:0] exp1(input bit p, input logic [7:0] d, old);
    return p ? (d & 8'h70) | (old & 8'h08) : d & 8'h78;
  endfunction
  task automatic chk(input string nm, input logic [7:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ========
  // Stimulus
  initial begin
    void'($urandom(51998));
    e1 = 8'h30;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    u_host.acc(0, 0, 8'h00, 8'h00, q);
    chk("addr_cfg", q, 8'hb0);
    for (int i = 0; i < 12; i++) begin
      u_host.acc(i[0], 0, 8'h01, 8'h00, q);
      chk("pwr_rst", q, e1);
      chk("pins", {4'h0, drv, aut, lvl, apd}, {4'h0, e1[6:3]});
      w = 8'($urandom()) & 8'hfe;
      u_host.acc(i[0], 1, 8'h01, w, q);
      chk("rst_pulse", {6'h00, lrst, frst}, {6'h00, w[1], 1'b0});
      e1 = exp1(i[0], w, e1);
    end
    strap = 7'($urandom());
    w = 8'($urandom()) | 8'h01;
    u_host.acc(0, 1, 8'h00, w, q);
    u_host.acc(1, 0, 8'h00, 8'h00, q);
    chk("addr_cfg", q, w);
    chk("own_addr", {1'b0, own}, {1'b0, w[7:1]});
    u_host.acc(1, 1, 8'h00, w & 8'hfe, q);
    u_host.acc(0, 0, 8'h00, 8'h00, q);
    chk("own_addr", {1'b0, own}, {1'b0, strap});
    w = 8'($urandom_range(255, 2));
    u_host.acc(0, 1, w, 8'hff, q);
    u_host.acc(0, 0, w, 8'h00, q);
    chk("unmapped", q, 8'h00);
    u_host.acc(0, 1, 8'h01, 8'hf9, q);
    chk("rst_pulse", {6'h00, lrst, frst}, 8'h03);
    u_host.acc(0, 0, 8'h00, 8'h00, q);
    chk("addr_cfg", q, 8'hb0);
    u_host.acc(1, 0, 8'h01, 8'h00, q);
    chk("pwr_rst", q, 8'h30);
    give_verdict();
  end
  always @(posedge tmo) begin
    num_errors++;
    give_verdict();
  end
endmodule
